// ==== dpc_consts.vh ====
// Constants for the display palette control register bank.
// Assumes a plain indexed register port on the 50 MHz system clock.
//
// Contract
// - Blanking 00 reset, 01 prepare, 11 normal.
// - Repeat codes give one, two, four times.
// - Pixel size codes give 1,2,4,8,16 bits.
// - Identification register read-only: type plus comparators.
// - Border index drives border; direct colour inverts bit7.
// - Palette uses low index; sprite uses 14 bits.
// - Plain index access has no side effect.
// - Low prefetch write loads palette prefetch, increments.
// - Prefetch write loads sprite prefetch, increments 14 bits.
// - Pixel value ANDed with mask indexes palette.
// - Palette data accesses currently sequenced colour element.
// - Only upper six palette data bits used.
// - Sequence register: current element and element order.
// - Sprite data accesses selected location, low-first packing.
// - Clock choice and select decoded together, 00/01.
// - Divider setting divides video clock for timing controller.
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH
`define DPC_ADDR_CTRL1 8'h50
`define DPC_ADDR_CTRL2 8'h51
`define DPC_ADDR_ID 8'h52
`define DPC_ADDR_CLK 8'h54
`define DPC_ADDR_BORDER 8'h55
`define DPC_ADDR_IDX_LO 8'h60
`define DPC_ADDR_IDX_HI 8'h61
`define DPC_ADDR_PF_LO 8'h62
`define DPC_ADDR_PF_HI 8'h63
`define DPC_ADDR_MASK 8'h64
`define DPC_ADDR_PDATA 8'h65
`define DPC_ADDR_PSEQ 8'h66
`define DPC_ADDR_PF_RED 8'h67
`define DPC_ADDR_PF_GREEN 8'h68
`define DPC_ADDR_PF_BLUE 8'h69
`define DPC_ADDR_SDATA 8'h6a
`define DPC_ADDR_SPF 8'h6b
`define DPC_ADDR_EXTCLK 8'h70
`define DPC_BLANK_RESET 2'h0
`define DPC_BLANK_PREP 2'h1
`define DPC_BLANK_NORMAL 2'h3
`define DPC_PS_DIRECT 3'h4
`define DPC_SPRITE_MAX 14'h3fff
`define DPC_MASK_RESET 8'hff
`define DPC_ELEM_RED 2'h0
`define DPC_ELEM_GREEN 2'h1
`define DPC_ELEM_BLUE 2'h2
`endif

// ==== dpc_regs.v ====
// Indexed register bank for the display, palette and sprite controls.
// Assumes a single-cycle strobe master on sys_clk; display status inputs
// come from other clock domains and are synchronised here.
`include "dpc_consts.vh"

module dpc_regs (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Display status inputs
    input wire [3:0] display_type,
    input wire red_dac_compare,
    input wire green_dac_compare,
    input wire blue_dac_compare,
    // Pixel path
    input wire [7:0] pixel_value,
    input wire border_active,
    output reg [7:0] palette_lookup_index,
    // Display controls
    output reg crt_timing_controller_reset,
    output reg display_blanked,
    output reg vga_passthrough_enable,
    output reg [2:0] horizontal_pixel_repeat,
    output reg [2:0] vertical_line_repeat,
    output reg [4:0] pixel_bits,
    output reg direct_colour,
    output reg video_clock_divide_by_two,
    output reg video_clock_valid
);

// ----------------------------------------------------------------------
// Storage
// ----------------------------------------------------------------------
reg [7:0] ctrl1;
reg [7:0] ctrl2;
reg [1:0] clk_sel;
reg [7:0] ext_clk;
reg [7:0] border;
reg [7:0] idx_lo;
reg [7:0] idx_hi;
reg [7:0] pal_mask;
reg [2:0] pseq;
reg [7:0] pf_red;
reg [7:0] pf_green;
reg [7:0] pf_blue;
reg [7:0] spf;
reg [5:0] pal_red [0:255];
reg [5:0] pal_green [0:255];
reg [5:0] pal_blue [0:255];
reg [7:0] sprite_buf [0:16383];
wire [6:0] id_sync;

wire [13:0] sprite_idx = {idx_hi[5:0], idx_lo};
wire [13:0] sprite_idx_inc = sprite_idx + 14'h0001;
// The sprite index steps inside fourteen bits, so a carry out of the top
// location wraps to zero and never leaks into the spare high bits.
wire [13:0] pf_hi_idx_inc = {reg_wdata[5:0], idx_lo} + 14'h0001;
wire [1:0] elem = pseq[1:0];
wire [1:0] blank_code = ctrl1[1:0];
wire wr_pdata = reg_wr && (reg_addr == `DPC_ADDR_PDATA);

// ----------------------------------------------------------------------
// Colour element sequencing
// ----------------------------------------------------------------------
// Order bit clear walks red, green, blue; set walks red, blue, green.
// Each data access advances; after the last element the index steps.
reg [1:0] next_elem;
reg elem_wrap;
always @* begin
    next_elem = `DPC_ELEM_RED;
    elem_wrap = 1'b0;
    case (elem)
        `DPC_ELEM_RED: begin
            next_elem = pseq[2] ? `DPC_ELEM_BLUE : `DPC_ELEM_GREEN;
        end
        `DPC_ELEM_GREEN: begin
            next_elem = pseq[2] ? `DPC_ELEM_RED : `DPC_ELEM_BLUE;
            elem_wrap = pseq[2];
        end
        `DPC_ELEM_BLUE: begin
            next_elem = pseq[2] ? `DPC_ELEM_GREEN : `DPC_ELEM_RED;
            elem_wrap = ~pseq[2];
        end
        default: begin
            next_elem = `DPC_ELEM_RED;
            elem_wrap = 1'b0;
        end
    endcase
end

// ----------------------------------------------------------------------
// Memories
// ----------------------------------------------------------------------
// Arrays have no reset so they map onto RAM.
always @(posedge sys_clk) begin
    if (wr_pdata) begin
        case (elem)
            `DPC_ELEM_RED: pal_red[idx_lo] <= reg_wdata[7:2];
            `DPC_ELEM_GREEN: pal_green[idx_lo] <= reg_wdata[7:2];
            `DPC_ELEM_BLUE: pal_blue[idx_lo] <= reg_wdata[7:2];
            default: pal_blue[idx_lo] <= pal_blue[idx_lo];
        endcase
    end
    if (reg_wr && reg_addr == `DPC_ADDR_SDATA) begin
        sprite_buf[sprite_idx] <= reg_wdata;
    end
end

// ----------------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------------
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        ctrl1 <= 8'h00;
        ctrl2 <= 8'h00;
        clk_sel <= 2'h0;
        ext_clk <= 8'h00;
        border <= 8'h00;
        idx_lo <= 8'h00;
        idx_hi <= 8'h00;
        pal_mask <= `DPC_MASK_RESET;
        pseq <= 3'h0;
        pf_red <= 8'h00;
        pf_green <= 8'h00;
        pf_blue <= 8'h00;
        spf <= 8'h00;
    end else if (reg_wr) begin
        case (reg_addr)
            `DPC_ADDR_CTRL1: ctrl1 <= reg_wdata;
            `DPC_ADDR_CTRL2: ctrl2 <= reg_wdata;
            `DPC_ADDR_CLK: clk_sel <= reg_wdata[1:0];
            `DPC_ADDR_EXTCLK: ext_clk <= reg_wdata;
            `DPC_ADDR_BORDER: border <= reg_wdata;
            `DPC_ADDR_IDX_LO: idx_lo <= reg_wdata;
            `DPC_ADDR_IDX_HI: idx_hi <= reg_wdata;
            `DPC_ADDR_PF_LO: begin
                pf_red <= {pal_red[reg_wdata], 2'h0};
                pf_green <= {pal_green[reg_wdata], 2'h0};
                pf_blue <= {pal_blue[reg_wdata], 2'h0};
                spf <= sprite_buf[{idx_hi[5:0], reg_wdata}];
                {idx_hi[5:0], idx_lo} <= {idx_hi[5:0], reg_wdata}
                    + 14'h0001;
            end
            `DPC_ADDR_PF_HI: begin
                spf <= sprite_buf[{reg_wdata[5:0], idx_lo}];
                idx_hi <= {2'h0, pf_hi_idx_inc[13:8]};
                idx_lo <= pf_hi_idx_inc[7:0];
            end
            `DPC_ADDR_MASK: pal_mask <= reg_wdata;
            `DPC_ADDR_PDATA: begin
                pseq[1:0] <= next_elem;
                if (elem_wrap) begin
                    idx_lo <= idx_lo + 8'h01;
                end
            end
            `DPC_ADDR_PSEQ: pseq <= reg_wdata[2:0];
            `DPC_ADDR_PF_RED: pf_red <= reg_wdata;
            `DPC_ADDR_PF_GREEN: pf_green <= reg_wdata;
            `DPC_ADDR_PF_BLUE: pf_blue <= reg_wdata;
            `DPC_ADDR_SDATA: begin
                idx_hi[5:0] <= sprite_idx_inc[13:8];
                idx_lo <= sprite_idx_inc[7:0];
            end
            `DPC_ADDR_SPF: spf <= reg_wdata;
            default: ctrl1 <= ctrl1;
        endcase
    end else if (reg_rd && reg_addr == `DPC_ADDR_PDATA) begin
        pseq[1:0] <= next_elem;
        if (elem_wrap) begin
            idx_lo <= idx_lo + 8'h01;
        end
    end
end

// ----------------------------------------------------------------------
// Read data
// ----------------------------------------------------------------------
// Reading the data register shows the element the sequencer points at,
// so it need not match the last write.
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        case (reg_addr)
            `DPC_ADDR_CTRL1: reg_rdata <= ctrl1;
            `DPC_ADDR_CTRL2: reg_rdata <= ctrl2;
            `DPC_ADDR_ID: reg_rdata <= {id_sync[6:4], 1'b0,
                id_sync[3:0]};
            `DPC_ADDR_CLK: reg_rdata <= {6'h00, clk_sel};
            `DPC_ADDR_EXTCLK: reg_rdata <= ext_clk;
            `DPC_ADDR_BORDER: reg_rdata <= border;
            `DPC_ADDR_IDX_LO: reg_rdata <= idx_lo;
            `DPC_ADDR_IDX_HI: reg_rdata <= idx_hi;
            `DPC_ADDR_PF_LO: reg_rdata <= idx_lo;
            `DPC_ADDR_PF_HI: reg_rdata <= idx_hi;
            `DPC_ADDR_MASK: reg_rdata <= pal_mask;
            `DPC_ADDR_PDATA: begin
                case (elem)
                    `DPC_ELEM_RED: reg_rdata <= {pal_red[idx_lo], 2'h0};
                    `DPC_ELEM_GREEN:
                        reg_rdata <= {pal_green[idx_lo], 2'h0};
                    `DPC_ELEM_BLUE: reg_rdata <= {pal_blue[idx_lo], 2'h0};
                    default: reg_rdata <= 8'h00;
                endcase
            end
            `DPC_ADDR_PSEQ: reg_rdata <= {5'h00, pseq};
            `DPC_ADDR_PF_RED: reg_rdata <= pf_red;
            `DPC_ADDR_PF_GREEN: reg_rdata <= pf_green;
            `DPC_ADDR_PF_BLUE: reg_rdata <= pf_blue;
            `DPC_ADDR_SDATA: reg_rdata <= sprite_buf[sprite_idx];
            `DPC_ADDR_SPF: reg_rdata <= spf;
            default: reg_rdata <= 8'h00;
        endcase
    end else begin
        reg_rdata <= 8'h00;
    end
end

// ----------------------------------------------------------------------
// Status synchroniser
// ----------------------------------------------------------------------
// Status pins are slow levels from the display cable, so two stages do.
dpc_sync2 #(
    .WIDTH(7)
) u_id_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({blue_dac_compare, green_dac_compare, red_dac_compare,
        display_type}),
    .sync_out(id_sync)
);

// ----------------------------------------------------------------------
// Scale factors
// ----------------------------------------------------------------------
// Both repeat fields use instances of one decoder module so their reserved
// codes behave alike.
wire [2:0] next_horizontal_pixel_repeat;
wire [2:0] next_vertical_line_repeat;

dpc_scale_decode #(
    .FACTOR_WIDTH(3)
) u_hscale (
    .code(ctrl2[5:4]),
    .factor(next_horizontal_pixel_repeat)
);

dpc_scale_decode #(
    .FACTOR_WIDTH(3)
) u_vscale (
    .code(ctrl2[7:6]),
    .factor(next_vertical_line_repeat)
);

// ----------------------------------------------------------------------
// Display control decode
// ----------------------------------------------------------------------
// Pixel input is assumed to share sys_clk with the serializer front end.
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        crt_timing_controller_reset <= 1'b1;
        display_blanked <= 1'b1;
        vga_passthrough_enable <= 1'b0;
        horizontal_pixel_repeat <= 3'h1;
        vertical_line_repeat <= 3'h1;
        pixel_bits <= 5'h01;
        direct_colour <= 1'b0;
        video_clock_divide_by_two <= 1'b0;
        video_clock_valid <= 1'b1;
    end else begin
        crt_timing_controller_reset <=
            (blank_code == `DPC_BLANK_RESET);
        display_blanked <= (blank_code != `DPC_BLANK_NORMAL);
        vga_passthrough_enable <= ctrl1[3];
        horizontal_pixel_repeat <= next_horizontal_pixel_repeat;
        vertical_line_repeat <= next_vertical_line_repeat;
        case (ctrl2[2:0])
            3'h0: pixel_bits <= 5'h01;
            3'h1: pixel_bits <= 5'h02;
            3'h2: pixel_bits <= 5'h04;
            3'h3: pixel_bits <= 5'h08;
            `DPC_PS_DIRECT: pixel_bits <= 5'h10;
            default: pixel_bits <= 5'h01;
        endcase
        direct_colour <= (ctrl2[2:0] == `DPC_PS_DIRECT);
        video_clock_divide_by_two <= clk_sel[0];
        video_clock_valid <= ({ext_clk[0], clk_sel[1]} == 2'h0);
    end
end

// ----------------------------------------------------------------------
// Pixel path
// ----------------------------------------------------------------------
// The border index bypasses the pixel mask; only picture pixels are
// masked before the lookup.
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        palette_lookup_index <= 8'h00;
    end else if (border_active) begin
        palette_lookup_index <= (ctrl2[2:0] == `DPC_PS_DIRECT) ?
            {~border[7], border[6:0]} : border;
    end else begin
        palette_lookup_index <= pixel_value & pal_mask;
    end
end

endmodule

// ----------------------------------------------------------------------
// Scale factor decode
// ----------------------------------------------------------------------
// Reserved codes fall back to no replication, so a stray write still
// leaves a usable picture.
module dpc_scale_decode #(
    parameter FACTOR_WIDTH = 3
) (
    // Field code
    input wire [1:0] code,
    // Replication factor, one-hot
    output reg [FACTOR_WIDTH-1:0] factor
);

localparam [FACTOR_WIDTH-1:0] ONE_TIME =
    {{(FACTOR_WIDTH-1){1'b0}}, 1'b1};

always @* begin
    case (code)
        2'h0: factor = ONE_TIME;
        2'h1: factor = ONE_TIME << 1;
        2'h2: factor = ONE_TIME << 2;
        default: factor = ONE_TIME;
    endcase
end

endmodule

// ----------------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------------
// Only the second stage is visible outside, so a metastable first stage
// never reaches the read path.
module dpc_sync2 #(
    parameter WIDTH = 7
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        meta <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta <= async_in;
        sync_out <= meta;
    end
end

endmodule

// ==== dpc_regs_checker.sv ====
// Checker for the display palette register bank.
// Bound to dpc_regs; it sees only the ports of that module.
module dpc_regs_checker (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Pixel path and controls
    input wire [7:0] pixel_value,
    input wire border_active,
    input wire [7:0] palette_lookup_index,
    input wire crt_timing_controller_reset,
    input wire [2:0] horizontal_pixel_repeat,
    input wire [4:0] pixel_bits,
    input wire direct_colour,
    input wire video_clock_divide_by_two
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Access sequences
    // ----------------------------------------
    sequence wr_at(a);
        reg_wr && reg_addr == a;
    endsequence
    sequence rd_at(a);
        reg_rd && reg_addr == a;
    endsequence
    blank_reset_a: assert property (wr_at(8'h50) |-> ##2
        crt_timing_controller_reset ==
        (($past(reg_wdata, 2) & 8'h03) == 8'h00))
        else $error("timing reset does not follow blanking code");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read reply");
    border_readback_a: assert property (
        wr_at(8'h55) ##2 rd_at(8'h55) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("border register read back wrong");
    lookup_mask_a: assert property (!border_active |=>
        (palette_lookup_index & ~$past(pixel_value)) == 8'h00)
        else $error("lookup index has bits outside pixel value");
    repeat_code_a: assert property ($onehot(horizontal_pixel_repeat))
        else $error("pixel repeat not one, two or four");
    pixel_size_a: assert property ($onehot(pixel_bits) &&
        direct_colour == (pixel_bits == 5'h10))
        else $error("pixel size decode wrong");
    clk_div_a: assert property (wr_at(8'h54) |-> ##2
        video_clock_divide_by_two == (($past(reg_wdata, 2) & 8'h01) != 8'h00))
        else $error("clock divider does not follow register");
    id_bit4_a: assert property (rd_at(8'h52) |=> !reg_rdata[4])
        else $error("identification unused bit not zero");
endmodule

bind dpc_regs dpc_regs_checker u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pixel_value(pixel_value),
    .border_active(border_active),
    .palette_lookup_index(palette_lookup_index),
    .crt_timing_controller_reset(crt_timing_controller_reset),
    .horizontal_pixel_repeat(horizontal_pixel_repeat),
    .pixel_bits(pixel_bits), .direct_colour(direct_colour),
    .video_clock_divide_by_two(video_clock_divide_by_two)
);

// ==== dpc_regs_tb_top.sv ====
// Self-checking bench for the display palette register bank.
// Assumes dpc_regs with a one-cycle strobe register port on sys_clk.
module dpc_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic border_active = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] pixel_value = 8'ha5;
    logic [3:0] display_type = 4'ha;
    logic red_dac_compare = 1'b1;
    logic green_dac_compare = 1'b0;
    logic blue_dac_compare = 1'b1;
    wire [7:0] reg_rdata, palette_lookup_index;
    wire [2:0] horizontal_pixel_repeat, vertical_line_repeat;
    wire [4:0] pixel_bits;
    wire crt_timing_controller_reset, display_blanked, direct_colour;
    wire vga_passthrough_enable, video_clock_divide_by_two;
    wire video_clock_valid;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    dpc_regs dut (
        .sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .display_type, .red_dac_compare, .green_dac_compare,
        .blue_dac_compare, .pixel_value, .border_active,
        .palette_lookup_index, .crt_timing_controller_reset,
        .display_blanked, .vga_passthrough_enable, .horizontal_pixel_repeat,
        .vertical_line_repeat, .pixel_bits, .direct_colour,
        .video_clock_divide_by_two, .video_clock_valid
    );
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Each access ends one rising edge after its strobe drops, so calls made
    // back to back never assign a strobe twice in one time step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk($sformatf("reg %h", a), exp, reg_rdata);
        @(posedge sys_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        logic [1:0] c;
        @(negedge sys_clk);
        chk("reset timing", 8'h01, 8'(crt_timing_controller_reset));
        @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(8'h64, 8'hff);
        for (int i = 0; i < 4; i++) begin
            c = i[1:0] ^ 2'h1;
            wr(8'h50, {4'h0, i[0], 1'b1, c});
            @(negedge sys_clk);
            chk("timing", 8'(c == 2'h0), 8'(crt_timing_controller_reset));
            chk("blank", 8'(c != 2'h3), 8'(display_blanked));
            chk("vga", 8'(i[0]), 8'(vga_passthrough_enable));
            @(posedge sys_clk);
        end
        for (int i = 0; i < 8; i++) begin
            c = ~i[1:0];
            wr(8'h51, {c, i[1:0], 1'b0, i[2:0]});
            @(negedge sys_clk);
            chk("hrep", (i[1:0] == 2'h3) ? 8'h01 : 8'h01 << i[1:0],
                8'(horizontal_pixel_repeat));
            chk("vrep", (c == 2'h3) ? 8'h01 : 8'h01 << c,
                8'(vertical_line_repeat));
            chk("bits", (i < 5) ? 8'h01 << i : 8'h01, 8'(pixel_bits));
            chk("direct", 8'(i == 4), 8'(direct_colour));
            @(posedge sys_clk);
            rd(8'h51, {c, i[1:0], 1'b0, i[2:0]});
            wr(8'h70, {7'h0, i[2]});
            wr(8'h54, {6'h0, i[1:0]});
            @(negedge sys_clk);
            chk("clk ok", 8'(i[2:1] == 2'h0), 8'(video_clock_valid));
            chk("div", 8'(i[0]), 8'(video_clock_divide_by_two));
            @(posedge sys_clk);
        end
        wr(8'h70, 8'h00);
        wr(8'h54, 8'h00);
        @(negedge sys_clk);
        chk("clk back", 8'h01, 8'(video_clock_valid));
        @(posedge sys_clk);
        wr(8'h51, 8'h00);
        wr(8'h52, 8'h00);
        rd(8'h52, 8'haa);
        wr(8'h53, 8'hff);
        rd(8'h53, 8'h00);
        wr(8'h64, 8'h0f);
        wr(8'h55, 8'h83);
        rd(8'h55, 8'h83);
        @(negedge sys_clk);
        chk("lookup", 8'h05, palette_lookup_index);
        @(posedge sys_clk);
        border_active <= 1'b1;
        wr(8'h51, 8'h04);
        @(negedge sys_clk);
        chk("border", 8'h03, palette_lookup_index);
        @(posedge sys_clk);
        wr(8'h60, 8'h10);
        rd(8'h60, 8'h10);
        rd(8'h67, 8'h00);
        wr(8'h66, 8'h00);
        wr(8'h65, 8'h84);
        wr(8'h65, 8'h48);
        wr(8'h65, 8'hff);
        rd(8'h60, 8'h11);
        wr(8'h62, 8'h10);
        rd(8'h67, 8'h84);
        rd(8'h68, 8'h48);
        rd(8'h69, 8'hfc);
        rd(8'h62, 8'h11);
        wr(8'h60, 8'h10);
        wr(8'h66, 8'h04);
        rd(8'h65, 8'h84);
        rd(8'h65, 8'hfc);
        rd(8'h65, 8'h48);
        rd(8'h60, 8'h11);
        wr(8'h67, 8'h3c);
        rd(8'h67, 8'h3c);
        wr(8'h66, 8'h00);
        wr(8'h60, 8'h20);
        wr(8'h65, 8'h00);
        wr(8'h65, 8'hc0);
        wr(8'h65, 8'h00);
        wr(8'h62, 8'h20);
        rd(8'h67, 8'h00);
        rd(8'h68, 8'hc0);
        rd(8'h69, 8'h00);
        wr(8'h61, 8'h3f);
        wr(8'h60, 8'hff);
        wr(8'h6a, 8'h5a);
        rd(8'h61, 8'h00);
        wr(8'h60, 8'hff);
        wr(8'h63, 8'h3f);
        rd(8'h6b, 8'h5a);
        rd(8'h60, 8'h00);
        rd(8'h63, 8'h00);
        wr(8'h61, 8'h3f);
        wr(8'h60, 8'hff);
        rd(8'h6a, 8'h5a);
        tally_and_finish();
    end
endmodule
